/* pkg/rhs_pkg.sv */
package rhs_pkg;
    localparam int NUM_PORTS = 2;
    // register indices (command codes); byte address is four times these
    localparam logic [7:0] IDX_HUB_STATUS = 8'h14;
    localparam logic [7:0] IDX_PORT1_STATUS = 8'h15;
    localparam logic [7:0] IDX_PORT2_STATUS = 8'h16;
    localparam logic [7:0] IDX_HUB_CONFIG = 8'h20;
    localparam logic [7:0] WR_CODE_BIT = 8'h80;
    // hub status fields
    localparam int HUB_CLR_WAKE = 31;
    localparam int HUB_OC_CHANGE = 17;
    localparam int HUB_SET_POWER = 16;
    localparam int HUB_WAKE_EN = 15;
    localparam int HUB_OC_FLAG = 1;
    localparam int HUB_CLR_POWER = 0;
    // port status fields
    localparam int PORT_RESET_CHANGE = 20;
    localparam int PORT_CONNECT_CHANGE = 16;
    localparam int PORT_POWER = 8;
    // hub config fields
    localparam int CFG_PER_PORT_POWER = 0;
    localparam int CFG_PER_PORT_OC = 1;
    localparam int CFG_MASK_LSB = 2;
    // 10 ms port reset at 40 ns clock
    localparam int PORT_RESET_MS = 10;
    localparam int CLK_PERIOD_NS = 40;
    localparam int PORT_RESET_CYCLES = PORT_RESET_MS * 1000000 / CLK_PERIOD_NS;
    localparam int RST_CNT_W = 18;
    localparam logic [31:0] PORT_RESET_VAL = 32'h0;
    localparam logic [31:0] RD_ZERO = 32'h0;

    // per-port hardware events from the port state machines
    typedef struct packed {
        logic connect_event;
        logic reset_start;
    } rhs_port_evt_s;

    typedef enum logic [1:0] {
        RHS_OPERATIONAL = 2'b00,
        RHS_SUSPEND = 2'b01,
        RHS_RESUME = 2'b10
    } rhs_state_e;
endpackage

/* src/rhs_sync.sv */
`timescale 1ns/1ps
module rhs_sync (
    input wire logic pclk, // system clock
    input wire logic presetn, // async reset, active low
    input wire logic d, // asynchronous level
    output logic q // synchronised level
);
    logic meta;

    // two stage synchroniser, meta read only by q
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= 1'b0;
            q <= 1'b0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

/* src/rhs_port.sv */
`timescale 1ns/1ps
module rhs_port (
    input wire logic pclk, // system clock
    input wire logic presetn, // async reset, active low
    input wire logic wr_en, // write to this port register
    input wire logic [31:0] wdata, // write data
    input wire logic power_set, // global set power
    input wire logic power_clr, // global clear power
    input wire logic masked, // port power mask bit
    input wire logic per_port_mode, // per-port power mode
    input wire rhs_pkg::rhs_port_evt_s evt, // hardware events
    output logic [31:0] status, // register read value
    output logic power_on, // port power state
    output logic connect_change // connect change flag
);
    logic reset_change;
    logic reset_busy;
    logic [rhs_pkg::RST_CNT_W-1:0] reset_cnt;
    logic global_ok;

    // masked ports ignore global commands only in per-port mode
    assign global_ok = !per_port_mode || !masked;

    // power state: per-port write bit or global strobes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_on <= 1'b0;
        end else if (power_set && global_ok) begin
            power_on <= 1'b1;
        end else if (power_clr && global_ok) begin
            power_on <= 1'b0;
        end else if (wr_en && wdata[rhs_pkg::PORT_POWER]) begin
            power_on <= 1'b1;
        end
    end

    // port reset timer, sets done flag when it expires
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reset_busy <= 1'b0;
            reset_cnt <= '0;
        end else if (reset_busy) begin
            if (reset_cnt == rhs_pkg::RST_CNT_W'(rhs_pkg::PORT_RESET_CYCLES - 1)) begin
                reset_busy <= 1'b0;
            end
            reset_cnt <= reset_cnt + 1'b1;
        end else if (evt.reset_start) begin
            reset_busy <= 1'b1;
            reset_cnt <= '0;
        end
    end

    // change flags: hardware set wins over a write-1 clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reset_change <= 1'b0;
            connect_change <= 1'b0;
        end else begin
            if (reset_busy &&
                    reset_cnt == rhs_pkg::RST_CNT_W'(rhs_pkg::PORT_RESET_CYCLES - 1)) begin
                reset_change <= 1'b1;
            end else if (wr_en && wdata[rhs_pkg::PORT_RESET_CHANGE]) begin
                reset_change <= 1'b0;
            end
            if (evt.connect_event) begin
                connect_change <= 1'b1;
            end else if (wr_en && wdata[rhs_pkg::PORT_CONNECT_CHANGE]) begin
                connect_change <= 1'b0;
            end
        end
    end

    // status low half, change flags high half
    always_comb begin
        status = rhs_pkg::PORT_RESET_VAL;
        status[rhs_pkg::PORT_RESET_CHANGE] = reset_change;
        status[rhs_pkg::PORT_CONNECT_CHANGE] = connect_change;
        status[rhs_pkg::PORT_POWER] = power_on;
    end
endmodule

/* src/rhs_top.sv */
`timescale 1ns/1ps
module rhs_top (
    input wire logic pclk, // system clock, 25 MHz
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [11:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    input wire logic overcurrent_pin, // global overcurrent sense, async
    input wire logic [1:0] connect_event, // per-port connect change pulses
    input wire logic [1:0] reset_start, // per-port reset request pulses
    input wire logic suspended, // controller in suspend
    output logic resume_seen_interrupt, // resume detected pulse
    output logic [1:0] port_power_state // per-port power state
);
    logic [7:0] idx;
    logic access;
    logic wr_hub;
    logic [1:0] wr_port;
    logic remote_wake_enable;
    logic overcurrent_change_flag;
    logic oc_sync;
    logic global_overcurrent_flag;
    logic oc_prev;
    logic power_switch_select;
    logic per_port_oc;
    logic [1:0] port_power_mask;
    logic set_all_power_strobe;
    logic clear_all_power_strobe;
    logic clear_wake_enable_strobe;
    logic [31:0] port_rd [rhs_pkg::NUM_PORTS];
    logic [1:0] port_power;
    logic [1:0] connect_change_flag;
    logic [1:0] connect_prev;
    logic wake_event;
    logic [31:0] next_rdata;
    logic next_err;
    logic mapped;

    // word index from byte address; write codes alias to read codes
    assign idx = paddr[9:2] & ~rhs_pkg::WR_CODE_BIT;
    assign access = psel && penable && !pready;
    assign mapped = idx == rhs_pkg::IDX_HUB_STATUS || idx == rhs_pkg::IDX_PORT1_STATUS ||
                    idx == rhs_pkg::IDX_PORT2_STATUS || idx == rhs_pkg::IDX_HUB_CONFIG;
    assign wr_hub = access && pwrite && idx == rhs_pkg::IDX_HUB_STATUS;
    assign wr_port[0] = access && pwrite && idx == rhs_pkg::IDX_PORT1_STATUS;
    assign wr_port[1] = access && pwrite && idx == rhs_pkg::IDX_PORT2_STATUS;

    // hub strobes, only writes of 1 act
    assign set_all_power_strobe = wr_hub && pwdata[rhs_pkg::HUB_SET_POWER];
    assign clear_all_power_strobe = wr_hub && pwdata[rhs_pkg::HUB_CLR_POWER];
    assign clear_wake_enable_strobe = wr_hub && pwdata[rhs_pkg::HUB_CLR_WAKE];

    // overcurrent sense comes from a pin
    rhs_sync u_oc_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d(overcurrent_pin),
        .q(oc_sync)
    );

    // global flag reads 0 when protection is per port
    assign global_overcurrent_flag = oc_sync && !per_port_oc;

    // one instance per downstream port
    genvar gi;
    generate
        for (gi = 0; gi < rhs_pkg::NUM_PORTS; gi++) begin : g_port
            rhs_pkg::rhs_port_evt_s evt;
            assign evt.connect_event = connect_event[gi];
            assign evt.reset_start = reset_start[gi];
            rhs_port u_port (
                .pclk(pclk),
                .presetn(presetn),
                .wr_en(wr_port[gi]),
                .wdata(pwdata),
                .power_set(set_all_power_strobe),
                .power_clr(clear_all_power_strobe),
                .masked(port_power_mask[gi]),
                .per_port_mode(power_switch_select),
                .evt(evt),
                .status(port_rd[gi]),
                .power_on(port_power[gi]),
                .connect_change(connect_change_flag[gi])
            );
        end
    endgenerate

    // remote wake enable: set by bit 15, clear by bit 31; clear wins if both
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            remote_wake_enable <= 1'b0;
        end else if (clear_wake_enable_strobe) begin
            remote_wake_enable <= 1'b0;
        end else if (wr_hub && pwdata[rhs_pkg::HUB_WAKE_EN]) begin
            remote_wake_enable <= 1'b1;
        end
    end

    // overcurrent change: edge against last cycle, set beats clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            oc_prev <= 1'b0;
            overcurrent_change_flag <= 1'b0;
        end else begin
            oc_prev <= global_overcurrent_flag;
            if (global_overcurrent_flag != oc_prev) begin
                overcurrent_change_flag <= 1'b1;
            end else if (wr_hub && pwdata[rhs_pkg::HUB_OC_CHANGE]) begin
                overcurrent_change_flag <= 1'b0;
            end
        end
    end

    // hub config register: power mode, oc mode, power mask
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_switch_select <= 1'b0;
            per_port_oc <= 1'b0;
            port_power_mask <= 2'h0;
        end else if (access && pwrite && idx == rhs_pkg::IDX_HUB_CONFIG) begin
            power_switch_select <= pwdata[rhs_pkg::CFG_PER_PORT_POWER];
            per_port_oc <= pwdata[rhs_pkg::CFG_PER_PORT_OC];
            port_power_mask <= pwdata[rhs_pkg::CFG_MASK_LSB +: 2];
        end
    end

    // connect change rising edge is the wake trigger
    assign wake_event = |(connect_change_flag & ~connect_prev);

    // resume only from suspend and only when wake enabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            connect_prev <= 2'h0;
            resume_seen_interrupt <= 1'b0;
        end else begin
            connect_prev <= connect_change_flag;
            resume_seen_interrupt <= wake_event && remote_wake_enable && suspended;
        end
    end

    // power state straight from flops for the output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_power_state <= 2'h0;
        end else begin
            port_power_state <= port_power;
        end
    end

    // read mux; hub bits 16 and 0 never stored so read 0
    always_comb begin
        next_rdata = rhs_pkg::RD_ZERO;
        next_err = !mapped;
        case (idx)
            rhs_pkg::IDX_HUB_STATUS: begin
                next_rdata[rhs_pkg::HUB_OC_CHANGE] = overcurrent_change_flag;
                next_rdata[rhs_pkg::HUB_WAKE_EN] = remote_wake_enable;
                next_rdata[rhs_pkg::HUB_OC_FLAG] = global_overcurrent_flag;
            end
            rhs_pkg::IDX_PORT1_STATUS: next_rdata = port_rd[0];
            rhs_pkg::IDX_PORT2_STATUS: next_rdata = port_rd[1];
            rhs_pkg::IDX_HUB_CONFIG: begin
                next_rdata[rhs_pkg::CFG_PER_PORT_POWER] = power_switch_select;
                next_rdata[rhs_pkg::CFG_PER_PORT_OC] = per_port_oc;
                next_rdata[rhs_pkg::CFG_MASK_LSB +: 2] = port_power_mask;
            end
            default: next_rdata = rhs_pkg::RD_ZERO;
        endcase
    end

    // apb answer: one wait state, ready in the second access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else if (access) begin
            pready <= 1'b1;
            prdata <= pwrite ? rhs_pkg::RD_ZERO : next_rdata;
            pslverr <= next_err;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end
endmodule

/* testbench/rhs_top_asserts.sv */
`timescale 1ns/1ps
module rhs_top_asserts (
    input wire logic pclk, // clock
    input wire logic presetn, // reset, active low
    input wire logic psel, // select
    input wire logic penable, // enable
    input wire logic pwrite, // direction
    input wire logic [11:0] paddr, // byte address
    input wire logic [31:0] pwdata, // write data
    input wire logic [31:0] prdata, // read data
    input wire logic pready, // ready
    input wire logic pslverr, // refused
    input wire logic suspended, // in suspend
    input wire logic resume_seen_interrupt, // resume pulse
    input wire logic [1:0] port_power_state // power per port
);
    logic [3:0] cfg;
    logic wake;
    logic wr_hub;
    logic [1:0] um;
    // completed hub write; index bit 7 is ignored so write codes alias
    assign wr_hub = pready && pwrite && !pslverr && paddr[8:2] == 7'h14;
    assign um = cfg[0] ? ~cfg[3:2] : 2'b11;
    // shadows lag the design by one cycle, harmless as writes are spaced
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg <= 4'h0;
            wake <= 1'b0;
        end else if (pready && pwrite && !pslverr) begin
            if (paddr[8:2] == 7'h20) begin
                cfg <= pwdata[3:0];
            end
            if (paddr[8:2] == 7'h14 && (pwdata[31] || pwdata[15])) begin
                wake <= !pwdata[31];
            end
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence access_s;
        psel && penable && !pready;
    endsequence
    ready_one_wait_a: assert property (setup_s ##1 access_s |=> pready)
        else $error("ready not one cycle after access");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    idle_no_ready_a: assert property (!(psel && penable) |=> !pready)
        else $error("ready without access");
    refused_zero_a: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("refusal malformed");
    power_on_a: assert property (wr_hub && pwdata[16] |=> (port_power_state & um) == um)
        else $error("set power missed a port");
    power_off_a: assert property (wr_hub && pwdata[0] && !pwdata[16]
        |=> (port_power_state & um) == 2'b00)
        else $error("clear power missed a port");
    masked_keep_a: assert property (wr_hub && (pwdata[16] || pwdata[0])
        |=> $stable(port_power_state & ~um))
        else $error("masked port changed");
    resume_wake_a: assert property (resume_seen_interrupt |-> wake && $past(suspended))
        else $error("resume without wake enable");
    resume_once_a: assert property (resume_seen_interrupt |=> !resume_seen_interrupt)
        else $error("resume pulse too long");
endmodule
bind rhs_top rhs_top_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .suspended(suspended),
    .resume_seen_interrupt(resume_seen_interrupt), .port_power_state(port_power_state));

/* testbench/rhs_host_model.sv */
`timescale 1ns/1ps
module rhs_host_model (
    input wire logic pclk, // clock
    output logic psel, // select
    output logic penable, // enable
    output logic pwrite, // direction
    output logic [11:0] paddr, // byte address
    output logic [31:0] pwdata, // write data
    input wire logic [31:0] prdata, // read data
    input wire logic pready, // ready
    input wire logic pslverr // refused
);
    // bus idle until the first transfer
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
    end
    // one transfer, held until ready is sampled; only the bench watchdog ends a hang
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= (a[8:2] == 7'h15 || a[8:2] == 7'h16) ? (d & 32'h001f_031f) : d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

/* testbench/rhs_top_tb_top.sv */
`timescale 1ns/1ps
module rhs_top_tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, overcurrent_pin, suspended;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [1:0] connect_event, reset_start, port_power_state;
    logic resume_seen_interrupt, e;
    int mismatches, total_checks;
    rhs_host_model host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    rhs_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .overcurrent_pin(overcurrent_pin), .connect_event(connect_event),
        .reset_start(reset_start), .suspended(suspended),
        .resume_seen_interrupt(resume_seen_interrupt), .port_power_state(port_power_state));
    // 25 MHz clock
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [11:0] a);
        host.xfer(1'b0, a, 32'h0, r, e);
    endtask
    // power output trails the write by one registered stage
    task automatic pwr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] exp);
        wr(a, d);
        repeat (2) @(posedge pclk);
        check("power", {30'h0, port_power_state}, {30'h0, exp});
    endtask
    task automatic pulse(input logic [1:0] p, output logic seen);
        seen = 1'b0;
        suspended <= 1'b1;
        connect_event <= p;
        @(posedge pclk);
        connect_event <= 2'b00;
        repeat (4) begin
            @(posedge pclk);
            if (resume_seen_interrupt === 1'b1) seen = 1'b1;
        end
    endtask
    task automatic complete_run;
        if (mismatches == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic test_reset;
        rd(12'h050);
        check("hub", r, 32'h0);
        rd(12'h054);
        check("port1", r, 32'h0);
        rd(12'h058);
        check("port2", r, 32'h0);
    endtask
    task automatic test_wake;
        wr(12'h250, 32'h0000_8000);
        rd(12'h050);
        check("wake set", r, 32'h0000_8000);
        wr(12'h050, 32'h0);
        rd(12'h050);
        check("wake kept", r, 32'h0000_8000);
        wr(12'h050, 32'h8000_0000);
        rd(12'h050);
        check("wake clear", r, 32'h0);
    endtask
    task automatic test_power;
        pwr(12'h050, 32'h0001_0000, 2'b11);
        rd(12'h050);
        check("hub low bits", r, 32'h0);
        pwr(12'h050, 32'h1, 2'b00);
        wr(12'h080, 32'h9);
        pwr(12'h050, 32'h0001_0000, 2'b01);
        pwr(12'h258, 32'h0000_0100, 2'b11);
        rd(12'h058);
        check("port2 power", r, 32'h0000_0100);
        pwr(12'h050, 32'h1, 2'b10);
        wr(12'h080, 32'h0);
        pwr(12'h050, 32'h1, 2'b00);
    endtask
    task automatic test_oc;
        overcurrent_pin <= 1'b1;
        repeat (4) @(posedge pclk);
        rd(12'h050);
        check("oc set", r, 32'h0002_0002);
        wr(12'h050, 32'h0002_0000);
        rd(12'h050);
        check("oc ack", r, 32'h0000_0002);
        overcurrent_pin <= 1'b0;
        repeat (4) @(posedge pclk);
        rd(12'h050);
        check("oc gone", r, 32'h0002_0000);
        wr(12'h080, 32'h2);
        overcurrent_pin <= 1'b1;
        repeat (4) @(posedge pclk);
        rd(12'h050);
        check("oc per port", r & 32'h2, 32'h0);
        wr(12'h080, 32'h0);
    endtask
    task automatic test_resume;
        wr(12'h050, 32'h0000_8000);
        pulse(2'b01, e);
        check("resume", {31'h0, e}, 32'h1);
        rd(12'h054);
        check("connect flag", r, 32'h0001_0000);
        wr(12'h254, 32'h0001_0000);
        rd(12'h054);
        check("connect clear", r, 32'h0);
        wr(12'h050, 32'h8000_0000);
        pulse(2'b10, e);
        check("no resume", {31'h0, e}, 32'h0);
    endtask
    // a third port register index must be refused
    task automatic test_unmapped;
        rd(12'h05c);
        check("refused", {31'h0, e}, 32'h1);
        check("refused data", r, 32'h0);
    endtask
    // reset-done flag stays clear while the long port timer still runs
    task automatic test_port_reset;
        reset_start <= 2'b01;
        @(posedge pclk);
        reset_start <= 2'b00;
        wr(12'h254, 32'h0010_0000);
        rd(12'h054);
        check("reset early", r & 32'h0010_0000, 32'h0);
    endtask
    // reset, then the scenarios in turn
    initial begin
        presetn = 1'b0;
        overcurrent_pin = 1'b0;
        connect_event = 2'b00;
        reset_start = 2'b00;
        suspended = 1'b0;
        mismatches = 0;
        total_checks = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        test_reset;
        test_wake;
        test_power;
        test_oc;
        test_resume;
        test_unmapped;
        test_port_reset;
        complete_run;
    end
    // run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge pclk);
        mismatches++;
        complete_run;
    end
endmodule
